// ==== design/pin_mux_defines.svh ====
// Constants for the port pin function select block
// Notes on behaviour
// - An analog-enabled pin has its digital output driver and input buffer off regardless of other bits except JTAG mode, which wins.
// - In JTAG mode the pull resistors on the test-port pins are disabled.
// - A selected negative converter input whose analog enable is 0 is tied to ground, not the pin.
// - The crystal input acts as a digital clock input when the oscillator source select is 11, pin 2.6 is selected and its direction bit is 0.
// - With serial pin enable set and no analog or JTAG, pin 1.6 carries serial data out or clock line.
// - With serial pin enable set and no analog or JTAG, pin 1.7 carries serial data in or data line.
// - In JTAG mode the direction of pin 1.7 is set by the JTAG logic, not by the port bits.
// - After reset pin 2.7 has the oscillator output selected until software clears its select bit.
`ifndef PIN_MUX_DEFINES_SVH
`define PIN_MUX_DEFINES_SVH

`define CH_PAIR2        3'h2
`define CH_PAIR3        3'h3
`define LF_SRC_DIGITAL  2'h3
`define P2_SEL_RESET    2'h3
`define P2_DIR_RESET    2'h2

`endif

// ==== design/pin_mux_pkg.sv ====
// Types for the port pin function select block
package pin_mux_pkg;

	typedef enum logic [2:0] {
		ROLE_GPIO   = 3'h0,
		ROLE_FUNC_IN = 3'h1,
		ROLE_FUNC_OUT = 3'h2,
		ROLE_SERIAL = 3'h3,
		ROLE_ANALOG = 3'h4,
		ROLE_JTAG   = 3'h5
	} role_type;

	typedef struct packed {
		logic out;   // Driven level
		logic oe_b;  // Output enable, low drives
		logic in_en; // Input buffer on
		logic pull_en; // Pull resistor allowed
	} pad_ctl_type;

endpackage : pin_mux_pkg

// ==== design/port_pin_function_select.sv ====
// Pin role selection for port 1 pins 4..7 and port 2 pins 6..7
`timescale 1ns/10ps
`include "pin_mux_defines.svh"

module port_pin_function_select
	import pin_mux_pkg::*;
(
	input  wire logic        clk_sys_i,                 // 250 MHz system clock
	input  wire logic        rst_b_i,                   // Async reset, active low
	input  wire logic [3:0]  port1_direction_i,         // Direction bits, pins 1.4..1.7
	input  wire logic [3:0]  port1_function_select_i,   // Select bits, pins 1.4..1.7
	input  wire logic [3:0]  port1_out_i,               // Output latch, pins 1.4..1.7
	input  wire logic [3:0]  port1_pull_en_i,           // Resistor enables, pins 1.4..1.7
	input  wire logic [3:0]  analog_input_enable_i,     // Analog enables, pins 1.4..1.7
	input  wire logic [2:0]  converter_channel_select_i,// Converter channel
	input  wire logic [3:0]  serial_if_pin_enable_i,    // Serial pin enables, 1.4..1.7
	input  wire logic        jtag_mode_i,               // Test port active
	input  wire logic        jtag_tdo_i,                // Test data out level
	input  wire logic        jtag_tdo_en_i,             // Test logic drives 1.7
	input  wire logic        sub_main_clock_out_i,      // Clock for pin 1.4
	input  wire logic        timer_out0_i,              // Timer output 0
	input  wire logic        timer_out1_i,              // Timer output 1
	input  wire logic        serial_sclk_i,             // Serial clock out
	input  wire logic        serial_sclk_en_i,          // Serial clock drive
	input  wire logic        serial_sdo_i,              // Data out / clock line
	input  wire logic        serial_sdo_en_i,           // Drive for 1.6
	input  wire logic        serial_sdi_i,              // Data line out level
	input  wire logic        serial_sdi_en_i,           // Drive for 1.7
	input  wire logic [1:0]  port2_direction_wr_i,      // New direction, pins 2.6..2.7
	input  wire logic [1:0]  port2_function_select_wr_i,// New select, pins 2.6..2.7
	input  wire logic        port2_wr_i,                // Port 2 write strobe
	input  wire logic [1:0]  port2_out_i,               // Output latch, pins 2.6..2.7
	input  wire logic [1:0]  lf_osc_source_select_i,    // Low-frequency source field
	input  wire logic        crystal_out_i,             // Oscillator drive level
	input  wire logic [3:0]  port1_pad_in_i,            // Pad levels, 1.4..1.7
	input  wire logic [1:0]  port2_pad_in_i,            // Pad levels, 2.6..2.7
	output pad_ctl_type [3:0] port1_pad_o,              // Pad controls, 1.4..1.7
	output pad_ctl_type [1:0] port2_pad_o,              // Pad controls, 2.6..2.7
	output role_type [3:0]   port1_role_o,              // Chosen role per pin
	output logic [3:0]       port1_in_o,                // Digital input to port
	output logic             capture1_input_b_o,        // Capture input from 1.6
	output logic             serial_sdi_o,              // Data in from 1.7
	output logic             converter_neg_to_ground_o, // Negative input on ground
	output logic             crystal_in_digital_o,      // Crystal pin is clock input
	output logic [1:0]       port2_function_select_o,   // Current select bits
	output logic [1:0]       port2_direction_o          // Current direction bits
);

	role_type    next_role [3:0];
	pad_ctl_type next_pad  [3:0];
	logic [2:0]  neg_pair;

	////////////////////////////////////////////////////////////////////////////////
	// Port 1 role choice

	function automatic role_type pick_role(input logic jtag, input logic ae,
		input logic usi, input logic sel, input logic dir);
		if (jtag)
			return ROLE_JTAG;
		else if (ae)
			return ROLE_ANALOG;
		else if (usi)
			return ROLE_SERIAL;
		else if (!sel)
			return ROLE_GPIO;
		else
			return dir ? ROLE_FUNC_OUT : ROLE_FUNC_IN;
	endfunction : pick_role

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			// Pin 1.4 has no serial function
			next_role[i] = pick_role(jtag_mode_i, analog_input_enable_i[i],
				(i != 0) && serial_if_pin_enable_i[i], port1_function_select_i[i],
				port1_direction_i[i]);
			next_pad[i] = '{out: port1_out_i[i], oe_b: !port1_direction_i[i],
				in_en: 1'b1, pull_en: port1_pull_en_i[i]};
			case (next_role[i])
				ROLE_JTAG: begin
					next_pad[i].pull_en = 1'b0;
					next_pad[i].oe_b    = 1'b1;
					next_pad[i].out     = 1'b0;
					if (i == 3) begin
						next_pad[i].oe_b = !jtag_tdo_en_i;
						next_pad[i].out  = jtag_tdo_i;
					end
				end
				ROLE_ANALOG: begin
					next_pad[i].oe_b  = 1'b1;
					next_pad[i].in_en = 1'b0;
					next_pad[i].out   = 1'b0;
				end
				ROLE_SERIAL: begin
					case (i)
						1: begin
							next_pad[i].out  = serial_sclk_i;
							next_pad[i].oe_b = !serial_sclk_en_i;
						end
						2: begin
							next_pad[i].out  = serial_sdo_i;
							next_pad[i].oe_b = !serial_sdo_en_i;
						end
						default: begin
							next_pad[i].out  = serial_sdi_i;
							next_pad[i].oe_b = !serial_sdi_en_i;
						end
					endcase
				end
				ROLE_FUNC_OUT: begin
					next_pad[i].oe_b = 1'b0;
					case (i)
						0: next_pad[i].out = sub_main_clock_out_i;
						1: next_pad[i].out = timer_out0_i;
						2: next_pad[i].out = timer_out1_i;
						default: next_pad[i].out = 1'b0;                     // Ground drive
					endcase
				end
				ROLE_FUNC_IN: next_pad[i].oe_b = 1'b1;
				default: next_pad[i].oe_b = !port1_direction_i[i];
			endcase
		end
	end

	always_comb begin
		for (int i = 0; i < 4; i++)
			port1_role_o[i] = next_role[i];
	end

	assign port1_pad_o = {next_pad[3], next_pad[2], next_pad[1], next_pad[0]};

	always_comb begin
		for (int i = 0; i < 4; i++)
			port1_in_o[i] = next_pad[i].in_en & port1_pad_in_i[i];
	end

	assign capture1_input_b_o = (next_role[2] == ROLE_FUNC_IN) & port1_pad_in_i[2];
	assign serial_sdi_o = (next_role[3] == ROLE_SERIAL) & port1_pad_in_i[3];

	////////////////////////////////////////////////////////////////////////////////
	// Negative converter inputs on pins 1.5 and 1.7

	assign neg_pair = converter_channel_select_i;
	assign converter_neg_to_ground_o =
		((neg_pair == `CH_PAIR2) && !analog_input_enable_i[1]) ||
		((neg_pair == `CH_PAIR3) && !analog_input_enable_i[3]);

	////////////////////////////////////////////////////////////////////////////////
	// Port 2 bits and crystal pins

	// Oscillator pins come up selected so the crystal runs from reset
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			port2_function_select_o <= `P2_SEL_RESET;
			port2_direction_o       <= `P2_DIR_RESET;
		end else if (port2_wr_i) begin
			port2_function_select_o <= port2_function_select_wr_i;
			port2_direction_o       <= port2_direction_wr_i;
		end
	end

	assign crystal_in_digital_o = port2_function_select_o[0] &&
		!port2_direction_o[0] && (lf_osc_source_select_i == `LF_SRC_DIGITAL);

	always_comb begin
		port2_pad_o[0] = '{out: port2_out_i[0], oe_b: !port2_direction_o[0],
			in_en: 1'b1, pull_en: 1'b0};
		if (port2_function_select_o[0]) begin
			port2_pad_o[0].out = timer_out1_i;
			port2_pad_o[0].in_en = crystal_in_digital_o;
		end
		port2_pad_o[1] = '{out: port2_out_i[1], oe_b: !port2_direction_o[1],
			in_en: 1'b1, pull_en: 1'b0};
		if (port2_function_select_o[1]) begin
			// Output driver stays on the pin while selected, even as input
			port2_pad_o[1].out  = port2_direction_o[1] ? crystal_out_i : 1'b0;
			port2_pad_o[1].oe_b = 1'b0;
			port2_pad_o[1].in_en = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	a_analog_off_driver: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		(!jtag_mode_i && analog_input_enable_i[2]) |->
		(port1_pad_o[2].oe_b && !port1_pad_o[2].in_en))
		else $error("Analog pin still driven");
	a_jtag_no_pull: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		jtag_mode_i |-> (port1_pad_o[0].pull_en == 1'b0 && port1_pad_o[3].pull_en == 1'b0))
		else $error("Pull active in JTAG mode");
	a_neg_ground: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		(converter_channel_select_i == 3'h3 && !analog_input_enable_i[3])
		|-> converter_neg_to_ground_o)
		else $error("Negative input not grounded");
	a_xin_digital: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		(port2_function_select_o[0] && !port2_direction_o[0] && lf_osc_source_select_i == 2'h3)
		|-> crystal_in_digital_o)
		else $error("Crystal input not digital");
	a_sdo_select: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		(!jtag_mode_i && !analog_input_enable_i[2] && serial_if_pin_enable_i[2])
		|-> port1_pad_o[2].out == serial_sdo_i)
		else $error("Pin 1.6 not on serial output");
	a_sdi_select: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		(!jtag_mode_i && !analog_input_enable_i[3] && serial_if_pin_enable_i[3])
		|-> serial_sdi_o == port1_pad_in_i[3])
		else $error("Pin 1.7 not on serial input");
	a_tdo_direction: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		jtag_mode_i |-> port1_pad_o[3].oe_b == !jtag_tdo_en_i)
		else $error("Pin 1.7 direction not from JTAG");
	a_crystal_out_reset: assert property (@(posedge clk_sys_i)
		$rose(rst_b_i) |-> port2_function_select_o[1] && port2_pad_o[1].oe_b == 1'b0)
		else $error("Oscillator output not selected after reset");
	a_gpio_dir: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		(!jtag_mode_i && !analog_input_enable_i[1] && !serial_if_pin_enable_i[1]
		&& !port1_function_select_i[1]) |-> port1_pad_o[1].oe_b == !port1_direction_i[1])
		else $error("GPIO direction wrong");
	a_role_priority: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		(!jtag_mode_i && analog_input_enable_i[3]) |-> port1_role_o[3] == ROLE_ANALOG)
		else $error("Analog did not win over serial");

endmodule : port_pin_function_select

// ==== verif/periph_model.sv ====
// Behavioural on-chip peripherals that feed the pin mux
`timescale 1ns/10ps
module periph_model (
	input  wire logic clk_sys_i,  // System clock
	input  wire logic drive_en_i, // Serial and test drivers on
	output logic      toggle_o,   // Clock, timer and data level
	output logic      drive_en_o  // Driver enable
);
	// One level that flips every cycle, so a stuck mux path cannot match it
	initial toggle_o = 1'b0;
	always @(posedge clk_sys_i) toggle_o <= ~toggle_o;
	assign drive_en_o = drive_en_i;
endmodule : periph_model

// ==== verif/testbench.sv ====
// Self-checking bench for the port pin function select block
`timescale 1ns/10ps
module testbench
	import pin_mux_pkg::*;
;
	logic              clk, rst_b, p2_wr, jtag, en, tg, en_w;
	logic [3:0]        dir, sel, p1_out, pull, ana, usi, pad_in, p1_in;
	logic [2:0]        chan;
	logic [1:0]        p2_dir, p2_sel, p2_out, lf, p2s, p2d;
	logic              cap, sdi, neg, xin_dig;
	pad_ctl_type [3:0] pad1;
	pad_ctl_type [1:0] pad2;
	role_type [3:0]    role;
	int                n_fail, num_checks;
	////////////////////////////////////////////////////////////////////////
	periph_model peer_u (.clk_sys_i(clk), .drive_en_i(en), .toggle_o(tg), .drive_en_o(en_w));
	port_pin_function_select dut_u (.clk_sys_i(clk), .rst_b_i(rst_b),
		.port1_direction_i(dir), .port1_function_select_i(sel), .port1_out_i(p1_out),
		.port1_pull_en_i(pull), .analog_input_enable_i(ana), .converter_channel_select_i(chan),
		.serial_if_pin_enable_i(usi), .jtag_mode_i(jtag), .jtag_tdo_i(~tg),
		.jtag_tdo_en_i(en_w), .sub_main_clock_out_i(tg), .timer_out0_i(tg),
		.timer_out1_i(~tg), .serial_sclk_i(tg), .serial_sclk_en_i(en_w), .serial_sdo_i(tg),
		.serial_sdo_en_i(en_w), .serial_sdi_i(~tg), .serial_sdi_en_i(en_w),
		.port2_direction_wr_i(p2_dir), .port2_function_select_wr_i(p2_sel),
		.port2_wr_i(p2_wr), .port2_out_i(p2_out), .lf_osc_source_select_i(lf),
		.crystal_out_i(tg), .port1_pad_in_i(pad_in), .port2_pad_in_i(2'h0),
		.port1_pad_o(pad1), .port2_pad_o(pad2), .port1_role_o(role), .port1_in_o(p1_in),
		.capture1_input_b_o(cap), .serial_sdi_o(sdi), .converter_neg_to_ground_o(neg),
		.crystal_in_digital_o(xin_dig), .port2_function_select_o(p2s),
		.port2_direction_o(p2d));
	////////////////////////////////////////////////////////////////////////
	task automatic step;
		@(posedge clk);
		#1;
	endtask : step
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("Error t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic end_sim;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : end_sim
	task automatic t_port2;
		chk({6'h0, p2s}, 8'h03);
		chk({6'h0, p2d}, 8'h02);
		chk({7'h0, pad2[1].oe_b}, 8'h00);
		chk({7'h0, pad2[1].out}, {7'h0, tg});
		step; p2_wr = 1'b1; p2_sel = 2'h0; p2_dir = 2'h0;
		step; p2_wr = 1'b0; #1;
		chk({6'h0, p2s}, 8'h00);
		chk({7'h0, pad2[1].oe_b}, 8'h01);
		$display("test port2 done");
	endtask : t_port2
	task automatic t_gpio;
		step; dir = 4'hF; p1_out = 4'hA; #1;
		for (int i = 0; i < 4; i++) begin
			chk({7'h0, pad1[i].oe_b}, 8'h00);
			chk({7'h0, pad1[i].out}, {7'h0, p1_out[i]});
			chk({5'h0, role[i]}, {5'h0, ROLE_GPIO});
		end
		step; dir = 4'h0; #1;
		for (int i = 0; i < 4; i++) chk({7'h0, pad1[i].oe_b}, 8'h01);
		step; sel = 4'h4; pad_in = 4'h4; #1;
		chk({5'h0, role[2]}, {5'h0, ROLE_FUNC_IN});
		chk({7'h0, cap}, 8'h01);
		chk({4'h0, p1_in}, 8'h04);
		step; sel = 4'hF; dir = 4'hF; pad_in = 4'h0; #1;
		chk({7'h0, pad1[0].out}, {7'h0, tg});
		chk({7'h0, pad1[2].out}, {7'h0, ~tg});
		chk({7'h0, pad1[3].oe_b}, 8'h00);
		chk({7'h0, pad1[3].out}, 8'h00);
		step; sel = 4'h0; dir = 4'h0;
		$display("test gpio done");
	endtask : t_gpio
	task automatic t_analog;
		// Every lower-priority select is set so only the analog bit can win
		step; ana = 4'hF; usi = 4'hE; sel = 4'hF; dir = 4'hF; en = 1'b1; pad_in = 4'hF; #1;
		chk({4'h0, p1_in}, 8'h00);
		for (int i = 0; i < 4; i++) begin
			chk({7'h0, pad1[i].oe_b}, 8'h01);
			chk({7'h0, pad1[i].in_en}, 8'h00);
			chk({5'h0, role[i]}, {5'h0, ROLE_ANALOG});
		end
		step; ana = 4'h0; sel = 4'h0; dir = 4'h0; pad_in = 4'h8; #1;
		chk({5'h0, role[2]}, {5'h0, ROLE_SERIAL});
		chk({7'h0, pad1[2].oe_b}, 8'h00);
		chk({7'h0, pad1[2].out}, {7'h0, tg});
		chk({5'h0, role[3]}, {5'h0, ROLE_SERIAL});
		chk({7'h0, sdi}, 8'h01);
		chk({7'h0, pad1[3].oe_b}, 8'h00);
		chk({7'h0, pad1[3].out}, {7'h0, ~tg});
		chk({5'h0, role[1]}, {5'h0, ROLE_SERIAL});
		chk({7'h0, pad1[1].out}, {7'h0, tg});
		step; pad_in = 4'h0; #1;
		chk({7'h0, sdi}, 8'h00);
		step; usi = 4'h0; en = 1'b0;
		$display("test analog serial done");
	endtask : t_analog
	task automatic t_jtag;
		step; jtag = 1'b1; pull = 4'hF; dir = 4'hF; usi = 4'hE; #1;
		for (int i = 0; i < 4; i++) begin
			chk({7'h0, pad1[i].pull_en}, 8'h00);
			chk({5'h0, role[i]}, {5'h0, ROLE_JTAG});
		end
		chk({7'h0, pad1[3].oe_b}, 8'h01);
		step; en = 1'b1; #1;
		chk({7'h0, pad1[3].oe_b}, 8'h00);
		chk({7'h0, pad1[3].out}, {7'h0, ~tg});
		step; jtag = 1'b0; pull = 4'h0; dir = 4'h0; usi = 4'h0; en = 1'b0;
		$display("test jtag done");
	endtask : t_jtag
	task automatic t_misc;
		step; chan = 3'h2; #1;
		chk({7'h0, neg}, 8'h01);
		step; ana = 4'h2; #1;
		chk({7'h0, neg}, 8'h00);
		step; chan = 3'h3; ana = 4'h0; #1;
		chk({7'h0, neg}, 8'h01);
		// A second reset brings the oscillator pins back to their selected state
		step; rst_b = 1'b0; #1;
		chk({6'h0, p2s}, 8'h03);
		step; rst_b = 1'b1; ana = 4'h8; lf = 2'h3; #1;
		chk({6'h0, p2d}, 8'h02);
		chk({7'h0, neg}, 8'h00);
		chk({7'h0, xin_dig}, 8'h01);
		step; lf = 2'h1; ana = 4'h0; #1;
		chk({7'h0, xin_dig}, 8'h00);
		$display("test converter crystal done");
	endtask : t_misc
	////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// The tests need under 100 cycles; the limit leaves wide margin
	initial begin
		#4000;
		n_fail++;
		$display("Error t=%0t watchdog expired", $time);
		end_sim;
	end
	initial begin
		{rst_b, p2_wr, jtag, en, dir, sel, p1_out, pull, ana, usi, pad_in} = '0;
		{chan, p2_dir, p2_sel, p2_out, lf} = '0;
		n_fail = 0;
		num_checks = 0;
		repeat (4) @(posedge clk);
		#1 rst_b = 1'b1;
		#1;
		t_port2;
		t_gpio;
		t_analog;
		t_jtag;
		t_misc;
		end_sim;
	end
endmodule : testbench
